// >>> hdl/optical_array_pkg.sv
// Shared constants, types and decode functions for the optical array command decoder.
package optical_array_pkg;

  // Frame geometry: three bytes per command.
  localparam int unsigned FRAME_BYTES     = 3;
  localparam int unsigned BYTE_BITS       = 8;
  localparam logic [4:0]  FRAME_BITS      = 5'h18;
  localparam logic [4:0]  FIRST_BYTE_END  = 5'h08;
  localparam logic [4:0]  SECOND_BYTE_END = 5'h10;
  localparam logic [4:0]  BIT_COUNT_RESET = 5'h00;

  // Command token and safety weight of every valid opcode.
  localparam int unsigned TOKEN_BIT       = 7;
  localparam logic [3:0]  OPCODE_WEIGHT   = 4'h4;

  // Opcodes of the instruction set.
  localparam logic [7:0] IDLE_COMMAND                     = 8'h00;
  localparam logic [7:0] CHIP_RESET_COMMAND               = 8'hF0;
  localparam logic [7:0] THRESHOLD_READBACK_COMMAND       = 8'hD8;
  localparam logic [7:0] THRESHOLD_WRITE_COMMAND          = 8'hCC;
  localparam logic [7:0] INTEGRATION_START_COMMAND        = 8'hB8;
  localparam logic [7:0] LONG_INTEGRATION_START_COMMAND   = 8'hB4;
  localparam logic [7:0] ONE_BIT_READOUT_COMMAND          = 8'h9C;
  localparam logic [7:0] ONE_AND_HALF_BIT_READOUT_COMMAND = 8'h96;
  localparam logic [7:0] FOUR_BIT_READOUT_COMMAND         = 8'h93;
  localparam logic [7:0] EIGHT_BIT_READOUT_COMMAND        = 8'h99;
  localparam logic [7:0] STRIPE_TEST_ONE_COMMAND          = 8'hE8;
  localparam logic [7:0] STRIPE_TEST_TWO_COMMAND          = 8'hE4;
  localparam logic [7:0] STRIPE_TEST_BOTH_COMMAND         = 8'hE2;
  localparam logic [7:0] STRIPE_TEST_ZERO_COMMAND         = 8'hE1;
  localparam logic [7:0] SLEEP_COMMAND                    = 8'hC6;
  localparam logic [7:0] WAKE_COMMAND                     = 8'hC3;

  // Values after power-on or chip reset, and the counter wrap points.
  localparam logic [7:0] THRESHOLD_PAIR_RESET = 8'hB3;
  localparam logic [4:0] COUNTER_RESET        = 5'h00;
  localparam logic [4:0] COUNTER_FULL         = 5'h1F;
  localparam logic [4:0] COUNTER_WRAP         = 5'h10;
  localparam logic       USER_MODE_FLAG       = 1'b1;
  localparam logic [7:0] ZERO_BYTE            = 8'h00;

  // Decoded command kinds.
  typedef enum logic [3:0] {
    CMD_NONE, CMD_CHIP_RESET, CMD_THR_READ, CMD_THR_WRITE, CMD_INTEGRATE,
    CMD_INTEGRATE_LONG, CMD_READOUT, CMD_STRIPE, CMD_SLEEP, CMD_WAKE
  } cmd_kind_type;

  // Read-out resolution held for the pixel encoder and the converter.
  typedef enum logic [1:0] {RES_1BIT, RES_1P5BIT, RES_4BIT, RES_8BIT} resolution_type;

  // Serial frame state.
  typedef enum logic [1:0] {FRAME_IDLE, FRAME_ACTIVE, FRAME_DONE} frame_state_type;

  // Command frame as received, first byte in the top bits.
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] param_hi;
    logic [7:0] param_lo;
  } cmd_frame_type;

  // Status header returned as the first byte of every frame.
  typedef struct packed {
    logic       awake;
    logic       reset_seen;
    logic       user_mode;
    logic [4:0] count;
  } status_header_type;

  // Synchronised pin view seen by the command logic.
  typedef struct packed {
    logic cs_n;
    logic mosi;
    logic sclk_rise;
    logic sclk_fall;
  } pin_view_type;

  // Map a first byte onto a command kind; unknown bytes give CMD_NONE.
  function automatic cmd_kind_type decode_opcode(input logic [7:0] op);
    cmd_kind_type kind;
    kind = CMD_NONE;
    if (op[TOKEN_BIT] && ($countones(op) == OPCODE_WEIGHT)) begin
      case (op)
        CHIP_RESET_COMMAND:               kind = CMD_CHIP_RESET;
        THRESHOLD_READBACK_COMMAND:       kind = CMD_THR_READ;
        THRESHOLD_WRITE_COMMAND:          kind = CMD_THR_WRITE;
        INTEGRATION_START_COMMAND:        kind = CMD_INTEGRATE;
        LONG_INTEGRATION_START_COMMAND:   kind = CMD_INTEGRATE_LONG;
        ONE_BIT_READOUT_COMMAND,
        ONE_AND_HALF_BIT_READOUT_COMMAND,
        FOUR_BIT_READOUT_COMMAND,
        EIGHT_BIT_READOUT_COMMAND:        kind = CMD_READOUT;
        STRIPE_TEST_ONE_COMMAND,
        STRIPE_TEST_TWO_COMMAND,
        STRIPE_TEST_BOTH_COMMAND,
        STRIPE_TEST_ZERO_COMMAND:         kind = CMD_STRIPE;
        SLEEP_COMMAND:                    kind = CMD_SLEEP;
        WAKE_COMMAND:                     kind = CMD_WAKE;
        default:                          kind = CMD_NONE;
      endcase
    end
    return kind;
  endfunction : decode_opcode

  // Next value of the command counter: all ones wraps to 10000, not zero.
  function automatic logic [4:0] next_count(input logic [4:0] cnt);
    logic [4:0] nxt;
    nxt = (cnt == COUNTER_FULL) ? COUNTER_WRAP : 5'(cnt + 5'h01);
    return nxt;
  endfunction : next_count

endpackage : optical_array_pkg

// >>> hdl/optical_array_spi_command_decoder.sv
// Serial command front end of the linear optical array: framing, status, thresholds.
//
// Summary of operation
// - A command is exactly three bytes: opcode byte then two parameter bytes.
// - Bit 7 clear in the first byte means no command; 0x00 is idle.
// - Three bytes are shifted back per command, the status header first.
// - Header bit 7 is 0 asleep, 1 awake; sleep C6, wake C3.
// - Header bit 6 is clear after power-on, set by the first chip reset.
// - Header bit 5 is 0 in maker test mode, 1 in user mode.
// - Header bits 4..0 count recognised commands.
// - Power-on or chip reset clears the counter to zero.
// - Counter wraps from 11111 to 10000, keeping its top bit set.
// - Only instruction set opcodes with exactly four ones are recognised.
// - Integration opcodes B8 and B4 carry a 16-bit time, high byte first.
// - Read-out opcodes 9C, 96, 93, 99 pick resolution; start and end pixels.
// - Stripe test opcodes E8, E4, E2, E1 use two zero parameter bytes.
// - Chip reset F0 restores power-up state, any time after a select gap.
// - Chip reset also ends sleep; master waits for analog wake-up.
// - 1.5-bit code: 10 above high, 00 below low, 01 between.
// - Low above high uses high for both; code LSB then stays 0.
// - 1-bit code compares with the high threshold only, no hysteresis.
// - Threshold write CC loads high and low nibbles from the second byte.
// - Thresholds reset to B and 3; master writes them only before integration.
// - Threshold read D8 returns header, threshold pair byte, zero byte.
// - Data in on rising clock, data out on falling; output driven while selected.
`timescale 1ns/1ps
module optical_array_spi_command_decoder
  import optical_array_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial pins
  input  wire logic        sclk_pin,
  input  wire logic        cs_n_pin,
  input  wire logic        mosi_pin,
  output logic             miso_out,
  output logic             miso_oe,
  // Pixel comparison path
  input  wire logic [3:0]  pixel_level,
  output logic [1:0]       pixel_code,
  // Device state
  output logic [7:0]       threshold_pair,
  output resolution_type   resolution,
  output logic             sleep_mode,
  output logic [4:0]       command_count,
  // Command strobes and parameters
  output logic             integration_start,
  output logic             integration_long,
  output logic [15:0]      integration_time,
  output logic             readout_start,
  output logic [7:0]       start_pixel,
  output logic [7:0]       end_pixel,
  output logic             stripe_test_start,
  output logic [7:0]       stripe_test_opcode
);

  pin_view_type      pins;
  frame_state_type   state_ff;
  frame_state_type   nxt_state;
  logic [4:0]        bit_cnt_ff;
  cmd_frame_type     rx_ff;
  logic [7:0]        tx_ff;
  logic              oe_ff;
  logic              exec_ff;
  cmd_kind_type      exec_kind;
  cmd_kind_type      first_kind;
  status_header_type header;
  logic [7:0]        thr_ff;
  logic              asleep_ff;
  logic              reset_seen_ff;
  logic [4:0]        count_ff;
  resolution_type    res_ff;
  logic              int_start_ff;
  logic              int_long_ff;
  logic [15:0]       int_time_ff;
  logic              ro_start_ff;
  logic [7:0]        start_px_ff;
  logic [7:0]        end_px_ff;
  logic              stripe_ff;
  logic [7:0]        stripe_op_ff;

  // Pins cross from the master's clock into ours through two flip-flops.
  serial_pin_sync u_sync (
    .clk      (clk),
    .rst      (rst),
    .sclk_pin (sclk_pin),
    .cs_n_pin (cs_n_pin),
    .mosi_pin (mosi_pin),
    .pins     (pins)
  );

  // The 1-bit and 1.5-bit codes follow the thresholds one clock later, through the encoder's register.
  pixel_threshold_encoder u_encoder (
    .clk            (clk),
    .rst            (rst),
    .threshold_pair (thr_ff),
    .resolution     (res_ff),
    .pixel_level    (pixel_level),
    .pixel_code     (pixel_code)
  );

  // Status header as it stands when a frame opens.
  assign header.awake      = ~asleep_ff;
  assign header.reset_seen = reset_seen_ff;
  assign header.user_mode  = USER_MODE_FLAG;
  assign header.count      = count_ff;

  // Kind of the first byte while the frame is still running, and of the completed frame.
  assign first_kind = decode_opcode(rx_ff.param_lo);
  assign exec_kind  = decode_opcode(rx_ff.opcode);

  // Frame sequencing: idle until selected, active while bits arrive, done after 24 bits.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FRAME_IDLE: begin
        if (!pins.cs_n) begin
          nxt_state = FRAME_ACTIVE;
        end
      end
      FRAME_ACTIVE: begin
        if (pins.cs_n) begin
          nxt_state = FRAME_IDLE;
        end else if (pins.sclk_rise && (bit_cnt_ff == FRAME_BITS - 5'h01)) begin
          nxt_state = FRAME_DONE;
        end
      end
      FRAME_DONE: begin
        if (pins.cs_n) begin
          nxt_state = FRAME_IDLE;
        end
      end
      default: nxt_state = FRAME_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= FRAME_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Bit counter and receive shifter; select high clears the counter, so a chip
  // reset can always be framed even in the middle of a long read-out.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_ff <= BIT_COUNT_RESET;
      rx_ff      <= '0;
    end else if (pins.cs_n) begin
      bit_cnt_ff <= BIT_COUNT_RESET;
    end else if (state_ff == FRAME_ACTIVE && pins.sclk_rise) begin
      bit_cnt_ff <= 5'(bit_cnt_ff + 5'h01);
      rx_ff      <= {rx_ff[22:0], pins.mosi};
    end
  end

  // One-cycle execute pulse when the third byte is complete; short frames do nothing.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exec_ff <= 1'b0;
    end else begin
      exec_ff <= (state_ff == FRAME_ACTIVE) && !pins.cs_n && pins.sclk_rise
                 && (bit_cnt_ff == FRAME_BITS - 5'h01);
    end
  end

  // Transmit path: header preloaded on select, next bytes loaded at byte boundaries. Shifts
  // wait for the first rise: the idle-high clock's leading fall would drop the header MSB.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ff <= ZERO_BYTE;
      oe_ff <= 1'b0;
    end else if (pins.cs_n) begin
      tx_ff <= ZERO_BYTE;
      oe_ff <= 1'b0;
    end else if (state_ff == FRAME_IDLE) begin
      tx_ff <= header;
      oe_ff <= 1'b1;
    end else if (pins.sclk_fall && (bit_cnt_ff != BIT_COUNT_RESET)) begin
      if (bit_cnt_ff == FIRST_BYTE_END) begin
        // Second byte: threshold pair for the read-back command, zero otherwise.
        tx_ff <= (first_kind == CMD_THR_READ) ? thr_ff : ZERO_BYTE;
      end else if (bit_cnt_ff == SECOND_BYTE_END) begin
        tx_ff <= ZERO_BYTE;
      end else begin
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  assign miso_out = tx_ff[7];
  assign miso_oe  = oe_ff;

  // Command counter: cleared by chip reset, stepped by every other recognised command.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= COUNTER_RESET;
    end else if (exec_ff) begin
      if (exec_kind == CMD_CHIP_RESET) begin
        count_ff <= COUNTER_RESET;
      end else if (exec_kind != CMD_NONE) begin
        count_ff <= next_count(count_ff);
      end
    end
  end

  // Chip-reset seen flag; the master owes one chip reset after power-on.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_seen_ff <= 1'b0;
    end else if (exec_ff && exec_kind == CMD_CHIP_RESET) begin
      reset_seen_ff <= 1'b1;
    end
  end

  // Sleep state; chip reset wakes as well, analog settling is the master's wait.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      asleep_ff <= 1'b0;
    end else if (exec_ff) begin
      if (exec_kind == CMD_SLEEP) begin
        asleep_ff <= 1'b1;
      end else if (exec_kind == CMD_WAKE || exec_kind == CMD_CHIP_RESET) begin
        asleep_ff <= 1'b0;
      end
    end
  end

  // Threshold pair: written at once, so a write during read-out shifts the codes live.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thr_ff <= THRESHOLD_PAIR_RESET;
    end else if (exec_ff) begin
      if (exec_kind == CMD_CHIP_RESET) begin
        thr_ff <= THRESHOLD_PAIR_RESET;
      end else if (exec_kind == CMD_THR_WRITE) begin
        thr_ff <= rx_ff.param_hi;
      end
    end
  end

  // Read-out resolution register, loaded by the read-out opcode.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_ff <= RES_8BIT;
    end else if (exec_ff) begin
      if (exec_kind == CMD_CHIP_RESET) begin
        res_ff <= RES_8BIT;
      end else if (exec_kind == CMD_READOUT) begin
        case (rx_ff.opcode)
          ONE_BIT_READOUT_COMMAND:          res_ff <= RES_1BIT;
          ONE_AND_HALF_BIT_READOUT_COMMAND: res_ff <= RES_1P5BIT;
          FOUR_BIT_READOUT_COMMAND:         res_ff <= RES_4BIT;
          default:                          res_ff <= RES_8BIT;
        endcase
      end
    end
  end

  // Integration request: time taken high byte then low byte.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_start_ff <= 1'b0;
      int_long_ff  <= 1'b0;
      int_time_ff  <= 16'h0000;
    end else begin
      int_start_ff <= 1'b0;
      if (exec_ff && exec_kind == CMD_CHIP_RESET) begin
        int_long_ff <= 1'b0;
        int_time_ff <= 16'h0000;
      end else if (exec_ff && (exec_kind == CMD_INTEGRATE ||
                               exec_kind == CMD_INTEGRATE_LONG)) begin
        int_start_ff <= 1'b1;
        int_long_ff  <= (exec_kind == CMD_INTEGRATE_LONG);
        int_time_ff  <= {rx_ff.param_hi, rx_ff.param_lo};
      end
    end
  end

  // Read-out request with its pixel window; clamping belongs to the read-out engine.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ro_start_ff <= 1'b0;
      start_px_ff <= ZERO_BYTE;
      end_px_ff   <= ZERO_BYTE;
    end else begin
      ro_start_ff <= 1'b0;
      if (exec_ff && exec_kind == CMD_CHIP_RESET) begin
        start_px_ff <= ZERO_BYTE;
        end_px_ff   <= ZERO_BYTE;
      end else if (exec_ff && exec_kind == CMD_READOUT) begin
        ro_start_ff <= 1'b1;
        start_px_ff <= rx_ff.param_hi;
        end_px_ff   <= rx_ff.param_lo;
      end
    end
  end

  // Stripe test request; the opcode itself tells which pattern to drive.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stripe_ff    <= 1'b0;
      stripe_op_ff <= ZERO_BYTE;
    end else begin
      stripe_ff <= 1'b0;
      if (exec_ff && exec_kind == CMD_CHIP_RESET) begin
        stripe_op_ff <= ZERO_BYTE;
      end else if (exec_ff && exec_kind == CMD_STRIPE) begin
        stripe_ff    <= 1'b1;
        stripe_op_ff <= rx_ff.opcode;
      end
    end
  end

  // Idle and unrecognised bytes decode to CMD_NONE, which no process above acts on.

  assign threshold_pair     = thr_ff;
  assign resolution         = res_ff;
  assign sleep_mode         = asleep_ff;
  assign command_count      = count_ff;
  assign integration_start  = int_start_ff;
  assign integration_long   = int_long_ff;
  assign integration_time   = int_time_ff;
  assign readout_start      = ro_start_ff;
  assign start_pixel        = start_px_ff;
  assign end_pixel          = end_px_ff;
  assign stripe_test_start  = stripe_ff;
  assign stripe_test_opcode = stripe_op_ff;

endmodule : optical_array_spi_command_decoder

// >>> hdl/pixel_threshold_encoder.sv
// Threshold encoder that turns a pixel level into its 1-bit or 1.5-bit output code.
`timescale 1ns/1ps
module pixel_threshold_encoder
  import optical_array_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // Settings
  input  wire logic [7:0]     threshold_pair,
  input  resolution_type      resolution,
  // Pixel in, code out
  input  wire logic [3:0]     pixel_level,
  output logic [1:0]          pixel_code
);

  logic [3:0] high_thr;
  logic [3:0] low_thr;
  logic [3:0] low_eff;
  logic [1:0] nxt_code;
  logic [1:0] code_ff;

  assign high_thr = threshold_pair[7:4];
  assign low_thr  = threshold_pair[3:0];
  // A low threshold above the high one collapses onto the high one.
  assign low_eff  = (low_thr > high_thr) ? high_thr : low_thr;

  // Equal levels count as not above, so with equal thresholds 01 never appears.
  always_comb begin
    nxt_code = 2'h0;
    if (resolution == RES_1P5BIT) begin
      if (pixel_level > high_thr) begin
        nxt_code = 2'h2;
      end else if (pixel_level > low_eff) begin
        nxt_code = 2'h1;
      end else begin
        nxt_code = 2'h0;
      end
    end else if (resolution == RES_1BIT) begin
      nxt_code = {1'b0, pixel_level > high_thr};
    end
  end

  // Registered so the top-level output comes from a flip-flop.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_ff <= 2'h0;
    end else begin
      code_ff <= nxt_code;
    end
  end

  assign pixel_code = code_ff;

endmodule : pixel_threshold_encoder

// >>> hdl/serial_pin_sync.sv
// Two-stage synchroniser for the serial pins and edge finder for the serial clock.
`timescale 1ns/1ps
module serial_pin_sync
  import optical_array_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Raw pins
  input  wire logic         sclk_pin,
  input  wire logic         cs_n_pin,
  input  wire logic         mosi_pin,
  // Synchronised view
  output pin_view_type      pins
);

  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic       sclk_last_ff;

  // Pins idle with the clock and select high; reset matches that so no edge is invented.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff      <= 3'h6;
      sync_ff      <= 3'h6;
      sclk_last_ff <= 1'b1;
    end else begin
      meta_ff      <= {sclk_pin, cs_n_pin, mosi_pin};
      sync_ff      <= meta_ff;
      sclk_last_ff <= sync_ff[2];
    end
  end

  // Only the second stage and the delayed copy feed logic.
  assign pins.cs_n      = sync_ff[1];
  assign pins.mosi      = sync_ff[0];
  assign pins.sclk_rise = sync_ff[2] & ~sclk_last_ff;
  assign pins.sclk_fall = ~sync_ff[2] & sclk_last_ff;

endmodule : serial_pin_sync

// >>> verification/optical_array_asserts.sv
// Concurrent checks on the command decoder ports.
`timescale 1ns/1ps
module optical_array_asserts
  import optical_array_pkg::*;
(
  // Clock, reset and select
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n_pin,
  // Observed outputs and pixel input
  input  wire logic       miso_oe,
  input  wire logic [3:0] pixel_level,
  input  wire logic [1:0] pixel_code,
  input  wire logic [7:0] threshold_pair,
  input  resolution_type  resolution,
  input  wire logic       sleep_mode,
  input  wire logic [4:0] command_count,
  input  wire logic       integration_start,
  input  wire logic       readout_start,
  input  wire logic       stripe_test_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Long enough for the synchronisers and the frame counter to settle.
  sequence quiet_s; cs_n_pin [*8]; endsequence
  sequence held_s; !cs_n_pin [*8]; endsequence

  // Low threshold above high collapses onto high, so the code LSB stays 0.
  function automatic logic [1:0] half(input logic [3:0] v, input logic [7:0] t);
    logic [3:0] lo;
    lo = (t[3:0] > t[7:4]) ? t[7:4] : t[3:0];
    return (v > t[7:4]) ? 2'h2 : ((v > lo) ? 2'h1 : 2'h0);
  endfunction : half

  oe_off_a: assert property (quiet_s |-> !miso_oe)
    else $error("output on while idle");
  oe_on_a: assert property (held_s |-> miso_oe)
    else $error("output off while selected");
  count_step_a: assert property (!$stable(command_count) |->
    command_count == 5'h00 ||
    command_count == (($past(command_count) == 5'h1F) ? 5'h10 : $past(command_count) + 5'h01))
    else $error("bad counter step");
  quiet_hold_a: assert property (quiet_s |=>
    $stable(command_count) && $stable(sleep_mode) && $stable(threshold_pair))
    else $error("state moved outside a frame");
  integ_pulse_a: assert property (integration_start |=> !integration_start)
    else $error("long pulse");
  read_pulse_a: assert property (readout_start |=> !readout_start)
    else $error("long pulse");
  stripe_pulse_a: assert property (stripe_test_start |=> !stripe_test_start)
    else $error("long pulse");
  code_half_a: assert property ($past(resolution) == RES_1P5BIT |->
    pixel_code == half($past(pixel_level), $past(threshold_pair)))
    else $error("bad 1.5-bit code");
  code_one_a: assert property ($past(resolution) == RES_1BIT |->
    pixel_code == {1'b0, $past(pixel_level) > $past(threshold_pair[7:4])})
    else $error("bad 1-bit code");
endmodule : optical_array_asserts

bind optical_array_spi_command_decoder optical_array_asserts checker_i (.clk, .rst, .cs_n_pin,
  .miso_oe, .pixel_level, .pixel_code, .threshold_pair, .resolution, .sleep_mode,
  .command_count, .integration_start, .readout_start, .stripe_test_start);

// >>> verification/optical_array_spi_command_decoder_tb_top.sv
// Self-checking bench for the serial command decoder.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module optical_array_spi_command_decoder_tb_top
  import optical_array_pkg::*;
;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic [3:0]     pixel_level = 4'h0;
  logic           sclk, cs_n, mosi, miso, miso_out, miso_oe, sleep_mode;
  logic           integration_start, integration_long, readout_start, stripe_test_start;
  logic [1:0]     pixel_code;
  logic [4:0]     command_count;
  logic [7:0]     threshold_pair, start_pixel, end_pixel, stripe_test_opcode;
  logic [15:0]    integration_time;
  resolution_type resolution;
  logic [4:0]     exp_cnt = 5'h00;
  logic [7:0]     exp_thr = 8'hB3;
  logic           awake = 1'b1;
  logic           crs = 1'b0;
  int             n_errors = 0;
  int             total_checks = 0;
  int             pulses = 0;
  logic [23:0]    bad [5] = '{24'h7C0000, 24'h780000, 24'h870000, 24'hF80000, 24'hF10000};
  logic [23:0]    good [14] = '{24'hCC5A00, 24'hD80000, 24'hB81234, 24'hB45678, 24'h9C028F,
    24'h96028F, 24'h93028F, 24'h99028F, 24'hE80000, 24'hE40000, 24'hE20000, 24'hE10000,
    24'hC60000, 24'hC30000};

  always #5 clk = ~clk;
  // A released data line shows a moving pattern rather than a stale bit.
  assign miso = miso_oe ? miso_out : ~clk;
  // Counted away from the launching edge so the pulse is settled when it is read.
  always @(negedge clk) if (integration_start || readout_start || stripe_test_start) pulses++;

  optical_array_spi_command_decoder DUT (.clk, .rst, .sclk_pin(sclk), .cs_n_pin(cs_n),
    .mosi_pin(mosi), .miso_out, .miso_oe, .pixel_level, .pixel_code, .threshold_pair,
    .resolution, .sleep_mode, .command_count, .integration_start, .integration_long,
    .integration_time, .readout_start, .start_pixel, .end_pixel, .stripe_test_start,
    .stripe_test_opcode);
  spi_master_model master (.clk, .sclk, .cs_n, .mosi, .miso);

  // One whole frame, then the reply and the state are held against the model.
  task automatic cmd(input logic [23:0] f, input logic rec);
    logic [23:0] rx;
    master.xfer(f, 24, rx);
    `CHK(rx[23:16], {awake, crs, 1'b1, exp_cnt})
    `CHK(rx[15:0], {(rec && f[23:16] == 8'hD8) ? exp_thr : 8'h00, 8'h00})
    if (f[23:16] == 8'hF0) begin
      exp_cnt = 5'h00;
      crs = 1'b1;
      awake = 1'b1;
      exp_thr = 8'hB3;
    end else if (rec) begin
      exp_cnt = (exp_cnt == 5'h1F) ? 5'h10 : exp_cnt + 5'h01;
      if (f[23:16] == 8'hCC) exp_thr = f[15:8];
      if (f[23:16] == 8'hC6) awake = 1'b0;
      if (f[23:16] == 8'hC3) awake = 1'b1;
      if (f[23:20] == 4'hB) `CHK(integration_time, f[15:0])
      if (f[23:20] == 4'hB) `CHK(integration_long, f[23:16] == 8'hB4)
      if (f[23:20] == 4'h9) `CHK({start_pixel, end_pixel}, f[15:0])
      if (f[23:20] == 4'hE) `CHK(stripe_test_opcode, f[23:16])
    end
    `CHK(command_count, exp_cnt)
    `CHK(threshold_pair, exp_thr)
    `CHK(sleep_mode, ~awake)
  endtask : cmd

  // Walk the pixel level through every value so the code checks fire.
  task automatic sweep();
    for (int v = 0; v < 16; v++) begin
      @(negedge clk);
      pixel_level = 4'(v);
    end
  endtask : sweep

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    #800us;
    n_errors++;
    end_of_test();
  end

  initial begin
    logic [23:0] rx;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    `CHK({threshold_pair, resolution, miso_oe}, {8'hB3, RES_8BIT, 1'b0})
    cmd(24'h000000, 1'b0);
    cmd(24'hF00000, 1'b0);
    foreach (bad[i]) cmd(bad[i], 1'b0);
    foreach (good[i]) cmd(good[i], 1'b1);
    `CHK(pulses, 10)
    // High A over low 5 leaves a band in which a level of 7 gives the middle code.
    cmd(24'hCCA500, 1'b1);
    cmd(24'h960A20, 1'b1);
    `CHK(resolution, RES_1P5BIT)
    sweep();
    @(negedge clk);
    pixel_level = 4'h7;
    repeat (2) @(negedge clk);
    `CHK(pixel_code, 2'h1)
    cmd(24'hCC3B00, 1'b1);
    sweep();
    cmd(24'h9C0A20, 1'b1);
    `CHK(resolution, RES_1BIT)
    sweep();
    repeat (24) cmd(24'hD80000, 1'b1);
    cmd(24'hC60000, 1'b1);
    master.xfer(24'hF00000, 10, rx);
    cmd(24'hF00000, 1'b0);
    end_of_test();
  end
endmodule : optical_array_spi_command_decoder_tb_top

// >>> verification/spi_master_model.sv
// Serial master model that frames commands and captures the returned bytes.
`timescale 1ns/1ps
module spi_master_model (
  // Clock used only to align pin changes
  input  wire logic clk,
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  // Pins rest at their idle levels: select and clock high, data low.
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // One frame of n bits; fewer than 24 cuts the frame short on purpose.
  task automatic xfer(input logic [23:0] tx, input int n, output logic [23:0] rx);
    rx = 24'h000000;
    @(negedge clk);
    cs_n = 1'b0;
    #80;
    for (int i = 23; i > 23 - n; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #80;
      sclk = 1'b1;
      rx[i] = miso;
      #80;
    end
    mosi = 1'b0;
    cs_n = 1'b1;
    #400;
  endtask : xfer
endmodule : spi_master_model
